//--- design/io_line_defines.vh
/*
 * Shared constants for the I/O line pull-up and function mux slice:
 * write and read selector codes, line count and reset values.
 * Assumes it is included by bare name from design files only.
 */
`ifndef IO_LINE_DEFINES_VH
`define IO_LINE_DEFINES_VH

`define LINE_COUNT 32

`define SEL_W 4
`define SEL_PULLUP_ENABLE 4'h0
`define SEL_PULLUP_DISABLE 4'h1
`define SEL_PULLUP_STATUS 4'h2
`define SEL_LINE_CONTROL_ENABLE 4'h3
`define SEL_LINE_CONTROL_DISABLE 4'h4
`define SEL_LINE_CONTROL_STATUS 4'h5
`define SEL_FUNCTION_A_SELECT 4'h6
`define SEL_FUNCTION_B_SELECT 4'h7
`define SEL_FUNCTION_SELECT_STATUS 4'h8
`define SEL_PIN_LEVEL_STATUS 4'h9

`define PULLUP_STATUS_RESET 32'h0000_0000
`define FUNCTION_SELECT_RESET 32'h0000_0000
`define LINE_CONTROL_RESET 32'hffff_ffff
`define MUXED_LINES_DEFAULT 32'hffff_ffff
`define ZERO_WORD 32'h0000_0000

`endif

//--- design/set_clear_bits.v
/*
 * A bank of status bits managed by a set strobe and a clear strobe.
 * Assumes one clock, and that the caller never raises both strobes at once.
 */
`timescale 1ns/1ns
module set_clear_bits #(
    parameter WIDTH = 32,
    parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b0}},
    parameter [WIDTH-1:0] FIXED_MASK = {WIDTH{1'b0}},
    parameter [WIDTH-1:0] FIXED_VAL = {WIDTH{1'b0}}
) (
    input wire mclk,
    input wire nrst,
    input wire set_stb,
    input wire clr_stb,
    input wire [WIDTH-1:0] data,
    output reg [WIDTH-1:0] status_q
);

    localparam [WIDTH-1:0] START_VAL = (RESET_VAL & ~FIXED_MASK) | (FIXED_VAL & FIXED_MASK);

    reg [WIDTH-1:0] status_d;

    always @*
    begin
        status_d = status_q;
        // RQ20: only ones act.
        if (set_stb)
            status_d = status_q | data;
        else if (clr_stb)
            status_d = status_q & ~data;
        // RQ11: fixed lines pinned.
        status_d = (status_d & ~FIXED_MASK) | (FIXED_VAL & FIXED_MASK);
    end

    // RQ21: visible next cycle.
    always @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
            status_q <= START_VAL;
        else
            status_q <= status_d;
    end

endmodule // set_clear_bits

//--- design/io_line_pullup_and_mux.v
/*
 * Per-line pull-up control, controller or peripheral ownership, and
 * peripheral A/B output selection for up to 32 I/O lines.
 * Assumes pad_in is asynchronous, everything else is on mclk, and
 * clk_enable comes from power management on the same clock.
 */
`timescale 1ns/1ns
`include "io_line_defines.vh"

// How it works
// RQ1: Thirty-two lines, one bit position each.
// RQ2: Writes apply even with clock gated.
// RQ3: Sampling and interrupt need running clock.
// RQ4: Controller clock gated off after reset.
// RQ5: Software enables clock before reading inputs.
// RQ6: Interrupt goes to user source 2-31.
// RQ7: Pull-up enable clears status, disable sets.
// RQ8: Pull-up writes ignore line assignment.
// RQ9: Pull-up status resets to zero.
// RQ10: Control enable sets, disable clears status.
// RQ11: Unmuxed lines ignore writes, read one.
// RQ12: Control status reset value per product.
// RQ13: A select clears, B select sets.
// RQ14: A/B steers output only, input shared.
// RQ15: Function select status resets to A.
// RQ16: A/B writes ignore line ownership.
// RQ17: Software writes select and control disable.
// RQ18: Interrupt inputs see pins, never blocked.
// RQ19: Peripheral owns line, drives pin.
// RQ20: Only written ones change; strobes read zero.
// RQ21: Status readable, updated next cycle.
module io_line_pullup_and_mux #(
    parameter LINES = `LINE_COUNT,
    parameter [LINES-1:0] MUXED_LINES = `MUXED_LINES_DEFAULT,
    parameter [LINES-1:0] LINE_CONTROL_RESET = `LINE_CONTROL_RESET
) (
    input wire mclk,
    input wire nrst,
    input wire clk_enable,
    input wire wr_strobe,
    input wire [`SEL_W-1:0] wr_sel,
    input wire [LINES-1:0] wr_data,
    input wire [`SEL_W-1:0] rd_sel,
    output reg [LINES-1:0] rd_data_q,
    input wire [LINES-1:0] gpio_out_data,
    input wire [LINES-1:0] gpio_out_en,
    input wire [LINES-1:0] change_irq_mask,
    input wire [LINES-1:0] periph_a_out,
    input wire [LINES-1:0] periph_a_oe,
    input wire [LINES-1:0] periph_b_out,
    input wire [LINES-1:0] periph_b_oe,
    input wire [LINES-1:0] pad_in,
    output reg [LINES-1:0] pad_out_q,
    output reg [LINES-1:0] pad_oe_q,
    output reg [LINES-1:0] pad_pullup_en_q,
    output reg [LINES-1:0] periph_a_in_q,
    output reg [LINES-1:0] periph_b_in_q,
    output reg fast_interrupt_input_q,
    output reg external_interrupt_input_q,
    output wire [LINES-1:0] pullup_status_reg,
    output wire [LINES-1:0] line_control_status_reg,
    output wire [LINES-1:0] function_select_status_reg,
    output reg [LINES-1:0] pin_level_q,
    output reg clk_on_q,
    output reg irq_q
);

    localparam [LINES-1:0] ALL_ZERO = {LINES{1'b0}};
    localparam [LINES-1:0] ALL_ONE = {LINES{1'b1}};

    reg [LINES-1:0] pad_meta_q;
    reg [LINES-1:0] pad_sync_q;
    reg [LINES-1:0] pin_prev_q;
    reg [LINES-1:0] pin_level_d;
    reg [LINES-1:0] pin_prev_d;
    reg primed_q;
    reg primed_d;
    reg [LINES-1:0] pad_out_d;
    reg [LINES-1:0] pad_oe_d;
    reg [LINES-1:0] rd_data_d;
    wire [LINES-1:0] change_seen;
    wire pullup_enable_wr;
    wire pullup_disable_wr;
    wire line_control_enable_wr;
    wire line_control_disable_wr;
    wire function_a_wr;
    wire function_b_wr;
    integer i;

    function is_write;
        input strobe;
        input [`SEL_W-1:0] sel;
        input [`SEL_W-1:0] code;
        begin
            is_write = strobe && (sel == code);
        end
    endfunction

    // RQ2: writes ignore clock gate.
    assign pullup_enable_wr = is_write(wr_strobe, wr_sel, `SEL_PULLUP_ENABLE);
    assign pullup_disable_wr = is_write(wr_strobe, wr_sel, `SEL_PULLUP_DISABLE);
    assign line_control_enable_wr = is_write(wr_strobe, wr_sel, `SEL_LINE_CONTROL_ENABLE);
    assign line_control_disable_wr = is_write(wr_strobe, wr_sel, `SEL_LINE_CONTROL_DISABLE);
    assign function_a_wr = is_write(wr_strobe, wr_sel, `SEL_FUNCTION_A_SELECT);
    assign function_b_wr = is_write(wr_strobe, wr_sel, `SEL_FUNCTION_B_SELECT);

    // RQ7: disable sets status.
    // RQ8: applies in any mode.
    // RQ9: resets to zero.
    set_clear_bits #(
        .WIDTH(LINES),
        .RESET_VAL(`PULLUP_STATUS_RESET),
        .FIXED_MASK(ALL_ZERO),
        .FIXED_VAL(ALL_ZERO)
    ) u_pullup (
        .mclk(mclk),
        .nrst(nrst),
        .set_stb(pullup_disable_wr),
        .clr_stb(pullup_enable_wr),
        .data(wr_data),
        .status_q(pullup_status_reg)
    );

    // RQ10: enable sets ownership.
    // RQ11: unmuxed lines stay one.
    // RQ12: product reset value.
    set_clear_bits #(
        .WIDTH(LINES),
        .RESET_VAL(LINE_CONTROL_RESET),
        .FIXED_MASK(~MUXED_LINES),
        .FIXED_VAL(ALL_ONE)
    ) u_line_control (
        .mclk(mclk),
        .nrst(nrst),
        .set_stb(line_control_enable_wr),
        .clr_stb(line_control_disable_wr),
        .data(wr_data),
        .status_q(line_control_status_reg)
    );

    // RQ13: B sets, A clears.
    // RQ15: resets to A.
    // RQ16: applies in any mode.
    set_clear_bits #(
        .WIDTH(LINES),
        .RESET_VAL(`FUNCTION_SELECT_RESET),
        .FIXED_MASK(ALL_ZERO),
        .FIXED_VAL(ALL_ZERO)
    ) u_function_select (
        .mclk(mclk),
        .nrst(nrst),
        .set_stb(function_b_wr),
        .clr_stb(function_a_wr),
        .data(wr_data),
        .status_q(function_select_status_reg)
    );

    // RQ4: gated off after reset.
    always @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
            clk_on_q <= 1'b0;
        else
            clk_on_q <= clk_enable;
    end

    // The pad synchroniser runs ungated so peripheral inputs never freeze.
    always @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            pad_meta_q <= ALL_ZERO;
            pad_sync_q <= ALL_ZERO;
        end
        else
        begin
            pad_meta_q <= pad_in;
            pad_sync_q <= pad_meta_q;
        end
    end

    // RQ14: input fans to both.
    // RQ18: interrupt inputs unblocked.
    always @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            periph_a_in_q <= ALL_ZERO;
            periph_b_in_q <= ALL_ZERO;
            fast_interrupt_input_q <= 1'b0;
            external_interrupt_input_q <= 1'b0;
        end
        else
        begin
            periph_a_in_q <= pad_sync_q;
            periph_b_in_q <= pad_sync_q;
            fast_interrupt_input_q <= pad_sync_q[0];
            external_interrupt_input_q <= pad_sync_q[1];
        end
    end

    // RQ3: sample only when clocked.
    // A gated controller holds the last level it saw, so reads go stale.
    always @*
    begin
        pin_level_d = pin_level_q;
        pin_prev_d = pin_prev_q;
        primed_d = primed_q;
        if (clk_on_q)
        begin
            pin_level_d = pad_sync_q;
            // The first sample after reset is its own reference, so a pin that
            // idles high on its pull-up does not raise a false change.
            pin_prev_d = primed_q ? pin_level_q : pad_sync_q;
            primed_d = 1'b1;
        end
    end

    always @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            pin_level_q <= ALL_ZERO;
            pin_prev_q <= ALL_ZERO;
            primed_q <= 1'b0;
        end
        else
        begin
            pin_level_q <= pin_level_d;
            pin_prev_q <= pin_prev_d;
            primed_q <= primed_d;
        end
    end

    // The pulse is not sticky, so whoever consumes it must catch its one cycle.
    assign change_seen = pin_level_q ^ pin_prev_q;

    // RQ3: interrupt only when clocked.
    // RQ6: single line to controller.
    always @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
            irq_q <= 1'b0;
        else
            irq_q <= clk_on_q && ((change_seen & change_irq_mask) != ALL_ZERO);
    end

    // RQ1: one bit per line.
    // RQ19: peripheral drives when released.
    always @*
    begin
        pad_out_d = gpio_out_data;
        pad_oe_d = gpio_out_en;
        for (i = 0; i < LINES; i = i + 1)
        begin
            if (!line_control_status_reg[i])
            begin
                pad_out_d[i] = function_select_status_reg[i] ? periph_b_out[i] : periph_a_out[i];
                pad_oe_d[i] = function_select_status_reg[i] ? periph_b_oe[i] : periph_a_oe[i];
            end
        end
    end

    // Registering the pad side costs a cycle but keeps pins glitch free.
    always @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            pad_out_q <= ALL_ZERO;
            pad_oe_q <= ALL_ZERO;
            pad_pullup_en_q <= ~`PULLUP_STATUS_RESET;
        end
        else
        begin
            pad_out_q <= pad_out_d;
            pad_oe_q <= pad_oe_d;
            // RQ7: status zero enables.
            pad_pullup_en_q <= ~pullup_status_reg;
        end
    end

    // RQ20: strobe selectors read zero.
    // RQ21: status readable anytime.
    always @*
    begin
        case (rd_sel)
            `SEL_PULLUP_STATUS: rd_data_d = pullup_status_reg;
            `SEL_LINE_CONTROL_STATUS: rd_data_d = line_control_status_reg;
            `SEL_FUNCTION_SELECT_STATUS: rd_data_d = function_select_status_reg;
            `SEL_PIN_LEVEL_STATUS: rd_data_d = pin_level_q;
            default: rd_data_d = ALL_ZERO;
        endcase
    end

    always @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
            rd_data_q <= ALL_ZERO;
        else
            rd_data_q <= rd_data_d;
    end

endmodule // io_line_pullup_and_mux

//--- test/io_line_checker.sv
/* Concurrent checks on the I/O line pull-up and function mux slice.
   Assumes it is bound to the top module and sees only its ports. */
`timescale 1ns/1ns
module io_line_checker #(
    parameter [31:0] MUXED_LINES = 32'hffff_ffff
) (
    input wire mclk,
    input wire nrst,
    input wire wr_strobe,
    input wire [3:0] wr_sel,
    input wire [31:0] wr_data,
    input wire [31:0] pullup_status_reg,
    input wire [31:0] line_control_status_reg,
    input wire [31:0] function_select_status_reg,
    input wire [31:0] pin_level_q,
    input wire [31:0] periph_a_in_q,
    input wire [31:0] periph_b_in_q,
    input wire clk_on_q,
    input wire irq_q
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!nrst);
    property p_pu_dis;
        wr_strobe && wr_sel == 4'h1 |=>
            pullup_status_reg == ($past(pullup_status_reg) | $past(wr_data));
    endproperty
    a_pu_dis: assert property (p_pu_dis) else $error("pull-up disable");
    property p_pu_en;
        wr_strobe && wr_sel == 4'h0 |=>
            pullup_status_reg == ($past(pullup_status_reg) & ~$past(wr_data));
    endproperty
    a_pu_en: assert property (p_pu_en) else $error("pull-up enable");
    property p_lc_en;
        wr_strobe && wr_sel == 4'h3 |=>
            line_control_status_reg == ($past(line_control_status_reg) | $past(wr_data));
    endproperty
    a_lc_en: assert property (p_lc_en) else $error("control enable");
    property p_lc_dis;
        wr_strobe && wr_sel == 4'h4 |=> line_control_status_reg ==
            ($past(line_control_status_reg) & ~($past(wr_data) & MUXED_LINES));
    endproperty
    a_lc_dis: assert property (p_lc_dis) else $error("control disable");
    property p_fs_b;
        wr_strobe && wr_sel == 4'h7 |=> function_select_status_reg ==
            ($past(function_select_status_reg) | $past(wr_data));
    endproperty
    a_fs_b: assert property (p_fs_b) else $error("b select");
    property p_fs_a;
        wr_strobe && wr_sel == 4'h6 |=> function_select_status_reg ==
            ($past(function_select_status_reg) & ~$past(wr_data));
    endproperty
    a_fs_a: assert property (p_fs_a) else $error("a select");
    property p_hold;
        !wr_strobe |=> $stable(pullup_status_reg) && $stable(line_control_status_reg)
            && $stable(function_select_status_reg);
    endproperty
    a_hold: assert property (p_hold) else $error("status moved without write");
    property p_freeze;
        !clk_on_q |=> $stable(pin_level_q);
    endproperty
    a_freeze: assert property (p_freeze) else $error("pin level moved while gated");
    property p_in;
        periph_a_in_q == periph_b_in_q;
    endproperty
    a_in: assert property (p_in) else $error("peripheral inputs differ");
    property p_irq_gate;
        !clk_on_q |=> !irq_q;
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("interrupt while gated");
endmodule // io_line_checker

bind io_line_pullup_and_mux io_line_checker #(.MUXED_LINES(MUXED_LINES)) u_chk (
    .mclk(mclk), .nrst(nrst), .wr_strobe(wr_strobe), .wr_sel(wr_sel), .wr_data(wr_data),
    .pullup_status_reg(pullup_status_reg), .line_control_status_reg(line_control_status_reg),
    .function_select_status_reg(function_select_status_reg), .pin_level_q(pin_level_q),
    .periph_a_in_q(periph_a_in_q), .periph_b_in_q(periph_b_in_q), .clk_on_q(clk_on_q),
    .irq_q(irq_q));

//--- test/io_pin_model.sv
/* Far side of the I/O lines: resolves each pad from the controller drive,
   an outside driver and the pull-up. Assumes the bench sets the outside driver. */
`timescale 1ns/1ns
module io_pin_model (
    input wire mclk,
    input wire [31:0] pad_out_q,
    input wire [31:0] pad_oe_q,
    input wire [31:0] pad_pullup_en_q,
    input wire [31:0] ext_en,
    input wire [31:0] ext_val,
    output wire [31:0] pad_in
);
    reg [31:0] float_q = 32'h0;
    // An undriven pin without pull-up wanders, so a lost drive never looks steady.
    always @(posedge mclk)
        float_q <= ~float_q;
    assign pad_in = (pad_oe_q & pad_out_q) | (~pad_oe_q & ext_en & ext_val)
        | (~pad_oe_q & ~ext_en & (pad_pullup_en_q | float_q));
endmodule // io_pin_model

//--- test/test_io_line_pullup_and_mux.sv
/* Self-checking bench for the I/O line pull-up and function mux slice.
   Assumes the pin model and the bound checker are compiled alongside. */
`timescale 1ns/1ns
module test_io_line_pullup_and_mux;
    localparam [31:0] lc = 32'h0000_0f0f;
    localparam [31:0] fs = 32'hc0f0_f0c0;
    reg mclk = 1'b0, nrst = 1'b0, clk_enable = 1'b0, wr_strobe = 1'b0, hit;
    reg [3:0] wr_sel = 4'h0, rd_sel = 4'h0;
    reg [31:0] wr_data = 32'h0, gpio_out_data = 32'h0, gpio_out_en = 32'h0;
    reg [31:0] change_irq_mask = 32'h0, periph_a_out = 32'h0, periph_a_oe = 32'h0;
    reg [31:0] periph_b_out = 32'h0, periph_b_oe = 32'h0, ext_en = 32'h0, ext_val = 32'h0;
    wire [31:0] rd_data_q, pad_in, pad_out_q, pad_oe_q, pad_pullup_en_q, periph_a_in_q;
    wire [31:0] periph_b_in_q, pullup_status_reg, line_control_status_reg;
    wire [31:0] function_select_status_reg, pin_level_q;
    wire fast_interrupt_input_q, external_interrupt_input_q, clk_on_q, irq_q;
    integer err_count = 0, n_checks = 0;
    always #5 mclk = ~mclk;
    // Lines 0 to 3 carry no peripheral, so control writes must miss them.
    io_line_pullup_and_mux #(.MUXED_LINES(32'hffff_fff0), .LINE_CONTROL_RESET(32'h00ff_00f0))
        u_dut (
        .mclk(mclk), .nrst(nrst), .clk_enable(clk_enable), .wr_strobe(wr_strobe),
        .wr_sel(wr_sel), .wr_data(wr_data), .rd_sel(rd_sel), .rd_data_q(rd_data_q),
        .gpio_out_data(gpio_out_data), .gpio_out_en(gpio_out_en),
        .change_irq_mask(change_irq_mask), .periph_a_out(periph_a_out),
        .periph_a_oe(periph_a_oe), .periph_b_out(periph_b_out), .periph_b_oe(periph_b_oe),
        .pad_in(pad_in), .pad_out_q(pad_out_q), .pad_oe_q(pad_oe_q),
        .pad_pullup_en_q(pad_pullup_en_q), .periph_a_in_q(periph_a_in_q),
        .periph_b_in_q(periph_b_in_q), .fast_interrupt_input_q(fast_interrupt_input_q),
        .external_interrupt_input_q(external_interrupt_input_q),
        .pullup_status_reg(pullup_status_reg),
        .line_control_status_reg(line_control_status_reg),
        .function_select_status_reg(function_select_status_reg),
        .pin_level_q(pin_level_q), .clk_on_q(clk_on_q), .irq_q(irq_q));
    io_pin_model u_pins (.mclk(mclk), .pad_out_q(pad_out_q), .pad_oe_q(pad_oe_q),
        .pad_pullup_en_q(pad_pullup_en_q), .ext_en(ext_en), .ext_val(ext_val), .pad_in(pad_in));
    task chk(input string what, input [31:0] seen, input [31:0] exp);
        n_checks = n_checks + 1;
        if (seen !== exp)
        begin
            err_count = err_count + 1;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task give_verdict;
        if (err_count == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task wr(input [3:0] s, input [31:0] d);
        wr_strobe <= 1'b1;
        wr_sel <= s;
        wr_data <= d;
        @(posedge mclk);
    endtask
    task idle(input integer n);
        wr_strobe <= 1'b0;
        repeat (n) @(posedge mclk);
    endtask
    task watch_irq(input integer n);
        hit = 1'b0;
        repeat (n)
        begin
            @(negedge mclk);
            hit = hit | irq_q;
        end
        @(posedge mclk);
    endtask
    task rd(input [3:0] s, input [31:0] exp, input string what);
        rd_sel <= s;
        @(posedge mclk);
        @(negedge mclk);
        chk(what, rd_data_q, exp);
        @(posedge mclk);
    endtask
    task t_reset;
        rd(4'h2, 32'h0, "pullup status");
        rd(4'h5, 32'h00ff_00ff, "control status");
        rd(4'h8, 32'h0, "function status");
        rd(4'h0, 32'h0, "write-only code");
        chk("pull-up pads", pad_pullup_en_q, 32'hffff_ffff);
        chk("clock on", {31'h0, clk_on_q}, 32'h0);
    endtask
    task t_pullup;
        wr(4'h1, 32'ha5a5_0003);
        wr(4'h0, 32'h0000_0001);
        wr(4'h1, 32'h0);
        wr(4'hf, 32'hffff_ffff);
        idle(2);
        rd(4'h2, 32'ha5a5_0002, "pullup status");
        chk("pull-up pads", pad_pullup_en_q, 32'h5a5a_fffd);
    endtask
    task t_ctrl;
        wr(4'h4, 32'hffff_ffff);
        idle(1);
        rd(4'h5, 32'h0000_000f, "control status");
        wr(4'h3, 32'h0000_0f03);
        idle(1);
        rd(4'h5, lc, "control status");
    endtask
    task t_absel;
        wr(4'h7, 32'hf0f0_f0f0);
        wr(4'h6, 32'h3000_0030);
        idle(1);
        rd(4'h8, fs, "function status");
    endtask
    task t_mux;
        gpio_out_data <= 32'h1234_5678;
        gpio_out_en <= 32'h0000_ffff;
        periph_a_out <= 32'haaaa_aaaa;
        periph_a_oe <= 32'hff00_ff00;
        periph_b_out <= 32'h5555_5555;
        periph_b_oe <= 32'h0ff0_0ff0;
        idle(3);
        chk("pad out", pad_out_q, (lc & gpio_out_data) | (~lc & ~fs & periph_a_out)
            | (~lc & fs & periph_b_out));
        chk("pad enable", pad_oe_q, (lc & gpio_out_en) | (~lc & ~fs & periph_a_oe)
            | (~lc & fs & periph_b_oe));
    endtask
    task t_input;
        gpio_out_en <= 32'h0;
        periph_a_oe <= 32'h0;
        periph_b_oe <= 32'h0;
        ext_en <= 32'hffff_ffff;
        ext_val <= 32'h8765_4321;
        change_irq_mask <= 32'hffff_ffff;
        idle(6);
        chk("peripheral a in", periph_a_in_q, 32'h8765_4321);
        chk("interrupt inputs", {30'h0, external_interrupt_input_q, fast_interrupt_input_q},
            32'h1);
        chk("gated level", pin_level_q, 32'h0);
        clk_enable <= 1'b1;
        watch_irq(6);
        chk("first sample change", {31'h0, hit}, 32'h0);
        rd(4'h9, 32'h8765_4321, "pin level");
        ext_val <= 32'h8765_4320;
        watch_irq(8);
        chk("change interrupt", {31'h0, hit}, 32'h1);
        clk_enable <= 1'b0;
        idle(2);
        ext_val <= 32'hffff_0000;
        watch_irq(6);
        chk("gated change", {31'h0, hit}, 32'h0);
        rd(4'h9, 32'h8765_4320, "held level");
        chk("peripheral b in", periph_b_in_q, 32'hffff_0000);
    endtask
    initial
    begin
        repeat (12) @(posedge mclk);
        nrst <= 1'b1;
        @(posedge mclk);
        t_reset;
        t_pullup;
        t_ctrl;
        t_absel;
        t_mux;
        t_input;
        give_verdict;
    end
endmodule // test_io_line_pullup_and_mux
